// >>> src/phy_interrupt_condition_logic.sv
// interrupt condition, mask and conditional write logic of the ring phy
// Notes on behaviour
// - the interrupt output is active while any condition bit and its mask bit are both set.
// - condition bit 0 is set on a transmitter request parity error when request parity checking is enabled.
// - condition bit 1 is set when the bus parity enable pin is high and a write carries bad parity.
// - condition bit 2 is set on any write to a read-only register, and that write changes nothing.
// - the read-only set is 07, 08, 10, 13, 14, 16, 18, 19, 1E and 1F.
// - condition bit 3 is set when a conditional write finds a guarded bit unequal to its compare bit.
// - in a conditional write every guarded bit that differs from its compare bit keeps its value.
// - condition pairs with compare 1A, transmit state with 1B, receive A with 1C, receive B with 1D.
// - the inhibit flag stays set until the host clears it by a write.
// - reset clears the mask register; mask bit n gates condition bit n.
// - the interrupt output is low when asserted and high otherwise.
`timescale 1ns/1ns
module phy_interrupt_condition_logic #(
   parameter bit ODD_PARITY = 1'b1
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire phy_int_pkg::mgmt_req_t mgmt_req_in,
   input wire logic mgmt_bus_parity_en_pin_in,
   input wire logic request_parity_err_in,
   input wire logic [3:0] upper_condition_set_in,
   input wire logic [7:0] receive_a_set_in,
   input wire logic [7:0] receive_b_set_in,
   output logic [7:0] mgmt_bus_data_out,
   output logic [7:0] transmit_state_out,
   output logic irq_n_out
);
   import phy_int_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   int_state_t st;
   int_state_t next_st;
   logic [3:0][7:0] guarded;
   logic [3:0][7:0] merged;
   logic [3:0] mismatch;
   logic parity_bad;
   logic read_only_hit;

   assign guarded[0] = st.interrupt_condition;
   assign guarded[1] = st.transmit_state;
   assign guarded[2] = st.receive_condition_a;
   assign guarded[3] = st.receive_condition_b;

   // ------------------------------------------------------------
   // conditional write merge, one per guarded register
   // ------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : gen_guard
      cond_write_merge #(
         .WIDTH(8)
      ) u_merge (
         .current_in(guarded[g]),
         .compare_in(st.compare[g]),
         .write_data_in(mgmt_req_in.data),
         .merged_out(merged[g]),
         .mismatch_out(mismatch[g])
      );
   end

   // parity sense is a parameter since the bus convention is board-level
   assign parity_bad = ODD_PARITY ? ~(^{mgmt_req_in.data, mgmt_req_in.parity})
                                  : (^{mgmt_req_in.data, mgmt_req_in.parity});

   // ------------------------------------------------------------
   // read-only address decode
   // ------------------------------------------------------------
   always_comb begin
      read_only_hit = 1'b0;
      if (mgmt_req_in.addr == ADDR_RECEIVE_STATE ||
          mgmt_req_in.addr == ADDR_NOISE_COUNT ||
          mgmt_req_in.addr == ADDR_NOISE_PRESCALE_COUNT ||
          mgmt_req_in.addr == ADDR_STATE_COUNT ||
          mgmt_req_in.addr == ADDR_STATE_PRESCALE_COUNT ||
          mgmt_req_in.addr == ADDR_LINK_ERROR_COUNT ||
          mgmt_req_in.addr == ADDR_DEVICE_IDENTIFICATION ||
          mgmt_req_in.addr == ADDR_INJECTION_COUNT ||
          mgmt_req_in.addr == ADDR_RESERVED_ZERO ||
          mgmt_req_in.addr == ADDR_RESERVED_ONE) begin
         read_only_hit = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [7:0] cond_set;
      logic inhibit;
      cond_set = 8'h00;
      inhibit = 1'b0;
      next_st = st;
      if (mgmt_req_in.wr) begin
         if (read_only_hit) begin
            cond_set[BIT_WRITE_REJECT_FLAG] = 1'b1;
         end else if (mgmt_req_in.addr == ADDR_INTERRUPT_CONDITION) begin
            next_st.interrupt_condition = merged[0];
            inhibit = mismatch[0];
         end else if (mgmt_req_in.addr == ADDR_INTERRUPT_MASK) begin
            next_st.interrupt_mask_register = mgmt_req_in.data;
         end else if (mgmt_req_in.addr == ADDR_TRANSMIT_STATE) begin
            next_st.transmit_state = merged[1];
            inhibit = mismatch[1];
         end else if (mgmt_req_in.addr == ADDR_RECEIVE_CONDITION_A) begin
            next_st.receive_condition_a = merged[2];
            inhibit = mismatch[2];
         end else if (mgmt_req_in.addr == ADDR_RECEIVE_CONDITION_B) begin
            next_st.receive_condition_b = merged[3];
            inhibit = mismatch[3];
         end else if (mgmt_req_in.addr == ADDR_INTERRUPT_COMPARE) begin
            next_st.compare[0] = mgmt_req_in.data;
         end else if (mgmt_req_in.addr == ADDR_TRANSMIT_STATE_COMPARE) begin
            next_st.compare[1] = mgmt_req_in.data;
         end else if (mgmt_req_in.addr == ADDR_RECEIVE_COMPARE_A) begin
            next_st.compare[2] = mgmt_req_in.data;
         end else if (mgmt_req_in.addr == ADDR_RECEIVE_COMPARE_B) begin
            next_st.compare[3] = mgmt_req_in.data;
         end
         if (mgmt_bus_parity_en_pin_in && parity_bad) begin
            cond_set[BIT_MGMT_BUS_PARITY_ERR] = 1'b1;
         end
      end
      cond_set[BIT_COND_WRITE_INHIBIT_FLAG] = inhibit;
      if (request_parity_err_in &&
          st.transmit_state[BIT_REQUEST_PARITY_CHECK_EN]) begin
         cond_set[BIT_REQUEST_DATA_PARITY_ERR] = 1'b1;
      end
      cond_set[7:BIT_UPPER_CONDITION_LSB] = upper_condition_set_in;
      // events are ored in after the write so a set never loses to a clear
      next_st.interrupt_condition = next_st.interrupt_condition
                                    | cond_set;
      next_st.receive_condition_a = next_st.receive_condition_a
                                    | receive_a_set_in;
      next_st.receive_condition_b = next_st.receive_condition_b
                                    | receive_b_set_in;
      // reads of registers owned elsewhere return zero here
      next_st.read_data = st.read_data;
      if (mgmt_req_in.rd) begin
         if (mgmt_req_in.addr == ADDR_INTERRUPT_CONDITION) begin
            next_st.read_data = st.interrupt_condition;
         end else if (mgmt_req_in.addr == ADDR_INTERRUPT_MASK) begin
            next_st.read_data = st.interrupt_mask_register;
         end else if (mgmt_req_in.addr == ADDR_TRANSMIT_STATE) begin
            next_st.read_data = st.transmit_state;
         end else if (mgmt_req_in.addr == ADDR_RECEIVE_CONDITION_A) begin
            next_st.read_data = st.receive_condition_a;
         end else if (mgmt_req_in.addr == ADDR_RECEIVE_CONDITION_B) begin
            next_st.read_data = st.receive_condition_b;
         end else if (mgmt_req_in.addr == ADDR_INTERRUPT_COMPARE) begin
            next_st.read_data = st.compare[0];
         end else if (mgmt_req_in.addr == ADDR_TRANSMIT_STATE_COMPARE) begin
            next_st.read_data = st.compare[1];
         end else if (mgmt_req_in.addr == ADDR_RECEIVE_COMPARE_A) begin
            next_st.read_data = st.compare[2];
         end else if (mgmt_req_in.addr == ADDR_RECEIVE_COMPARE_B) begin
            next_st.read_data = st.compare[3];
         end else begin
            next_st.read_data = READ_ZERO;
         end
      end
      // low while any unmasked condition is pending
      next_st.irq_n = ~|(next_st.interrupt_condition
                         & next_st.interrupt_mask_register);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         st.interrupt_condition <= RST_INTERRUPT_CONDITION;
         st.interrupt_mask_register <= RST_INTERRUPT_MASK;
         st.transmit_state <= RST_TRANSMIT_STATE;
         st.receive_condition_a <= RST_RECEIVE_CONDITION;
         st.receive_condition_b <= RST_RECEIVE_CONDITION;
         st.compare <= {4{RST_COMPARE}};
         st.read_data <= READ_ZERO;
         st.irq_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign mgmt_bus_data_out = st.read_data;
   assign transmit_state_out = st.transmit_state;
   assign irq_n_out = st.irq_n;

endmodule : phy_interrupt_condition_logic

// >>> src/phy_int_pkg.sv
// package: register map, reset values and carrier types of the interrupt logic
package phy_int_pkg;

   // ------------------------------------------------------------
   // register offsets on the management control bus
   // ------------------------------------------------------------
   localparam logic [4:0] ADDR_INTERRUPT_CONDITION = 5'h02;
   localparam logic [4:0] ADDR_INTERRUPT_MASK = 5'h03;
   localparam logic [4:0] ADDR_TRANSMIT_STATE = 5'h04;
   localparam logic [4:0] ADDR_NOISE_COUNT = 5'h07;
   localparam logic [4:0] ADDR_RECEIVE_STATE = 5'h08;
   localparam logic [4:0] ADDR_RECEIVE_CONDITION_A = 5'h09;
   localparam logic [4:0] ADDR_RECEIVE_CONDITION_B = 5'h0A;
   localparam logic [4:0] ADDR_NOISE_PRESCALE_COUNT = 5'h10;
   localparam logic [4:0] ADDR_STATE_COUNT = 5'h13;
   localparam logic [4:0] ADDR_STATE_PRESCALE_COUNT = 5'h14;
   localparam logic [4:0] ADDR_LINK_ERROR_COUNT = 5'h16;
   localparam logic [4:0] ADDR_DEVICE_IDENTIFICATION = 5'h18;
   localparam logic [4:0] ADDR_INJECTION_COUNT = 5'h19;
   localparam logic [4:0] ADDR_INTERRUPT_COMPARE = 5'h1A;
   localparam logic [4:0] ADDR_TRANSMIT_STATE_COMPARE = 5'h1B;
   localparam logic [4:0] ADDR_RECEIVE_COMPARE_A = 5'h1C;
   localparam logic [4:0] ADDR_RECEIVE_COMPARE_B = 5'h1D;
   localparam logic [4:0] ADDR_RESERVED_ZERO = 5'h1E;
   localparam logic [4:0] ADDR_RESERVED_ONE = 5'h1F;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_REQUEST_DATA_PARITY_ERR = 0;
   localparam int BIT_MGMT_BUS_PARITY_ERR = 1;
   localparam int BIT_WRITE_REJECT_FLAG = 2;
   localparam int BIT_COND_WRITE_INHIBIT_FLAG = 3;
   localparam int BIT_UPPER_CONDITION_LSB = 4;
   localparam int BIT_REQUEST_PARITY_CHECK_EN = 6;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_INTERRUPT_CONDITION = 8'h00;
   localparam logic [7:0] RST_INTERRUPT_MASK = 8'h00;
   localparam logic [7:0] RST_TRANSMIT_STATE = 8'hA2;
   localparam logic [7:0] RST_RECEIVE_CONDITION = 8'h00;
   localparam logic [7:0] RST_COMPARE = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [7:0] data;
      logic parity;
   } mgmt_req_t;

   typedef struct packed {
      logic [7:0] interrupt_condition;
      logic [7:0] interrupt_mask_register;
      logic [7:0] transmit_state;
      logic [7:0] receive_condition_a;
      logic [7:0] receive_condition_b;
      logic [3:0][7:0] compare;
      logic [7:0] read_data;
      logic irq_n;
   } int_state_t;

endpackage : phy_int_pkg

// >>> src/cond_write_merge.sv
// conditional write merge of one guarded register against its compare copy
`timescale 1ns/1ns
module cond_write_merge #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] current_in,
   input wire logic [WIDTH-1:0] compare_in,
   input wire logic [WIDTH-1:0] write_data_in,
   output logic [WIDTH-1:0] merged_out,
   output logic mismatch_out
);
   logic [WIDTH-1:0] differ;

   // bits that moved since software read them keep their value
   assign differ = current_in ^ compare_in;
   assign merged_out = (write_data_in & ~differ) | (current_in & differ);
   assign mismatch_out = |differ;

endmodule : cond_write_merge

// >>> tb/mgmt_host_model.sv
// host model: drives single cycles on the management control bus
`timescale 1ns/1ns
module mgmt_host_model #(
   parameter bit ODD_PARITY = 1'b1
) (
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   output phy_int_pkg::mgmt_req_t req_out
);
   import phy_int_pkg::*;
   initial req_out = '0;
   // one access then an idle edge, so calls never collide in a time step
   task automatic access(input logic w, input logic [4:0] a,
      input logic [7:0] d, input logic bad, output logic [7:0] q);
      @(posedge clk_in);
      // good parity gives data plus parity an odd count when ODD_PARITY
      req_out <= {w, !w, a, d, (^d ^ ODD_PARITY) ^ bad};
      @(posedge clk_in);
      req_out <= '0;
      @(negedge clk_in);
      q = rdata_in;
   endtask : access
   // compare copy first, else fresh events would be wiped
   task automatic cond_write(input logic [4:0] c, a,
      input logic [7:0] seen, d);
      logic [7:0] q;
      access(1'b1, c, seen, 1'b0, q);
      access(1'b1, a, d, 1'b0, q);
   endtask : cond_write
endmodule : mgmt_host_model

// >>> tb/phy_interrupt_condition_logic_assertions.sv
// port assertions of the interrupt condition logic
`timescale 1ns/1ns
module phy_interrupt_condition_logic_assertions
   import phy_int_pkg::*;
#(
   parameter bit ODD_PARITY = 1'b1
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire phy_int_pkg::mgmt_req_t mgmt_req_in,
   input wire logic mgmt_bus_parity_en_pin_in,
   input wire logic request_parity_err_in,
   input wire logic [3:0] upper_condition_set_in,
   input wire logic [7:0] receive_a_set_in,
   input wire logic [7:0] receive_b_set_in,
   input wire logic [7:0] mgmt_bus_data_out,
   input wire logic [7:0] transmit_state_out,
   input wire logic irq_n_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);
   logic ro, ev, bad, w4;
   assign ro = mgmt_req_in.addr inside {5'h07, 5'h08, 5'h10, 5'h13,
      5'h14, 5'h16, 5'h18, 5'h19, 5'h1E, 5'h1F};
   assign ev = request_parity_err_in || (|upper_condition_set_in) ||
      (|receive_a_set_in) || (|receive_b_set_in);
   assign bad = mgmt_bus_parity_en_pin_in &&
      ((^{mgmt_req_in.data, mgmt_req_in.parity}) != ODD_PARITY);
   assign w4 = mgmt_req_in.wr && mgmt_req_in.addr == ADDR_TRANSMIT_STATE;
   post_reset_irq_a: assert property ($past(srst_in) |-> irq_n_out)
      else $error("interrupt active right after reset");
   ro_read_zero_a: assert property (mgmt_req_in.rd && ro |=>
      mgmt_bus_data_out == 8'h00) else $error("read-only read not zero");
   ro_write_keep_a: assert property (mgmt_req_in.wr && ro |=>
      $stable(transmit_state_out)) else $error("rejected write took effect");
   ts_hold_a: assert property (!w4 |=> $stable(transmit_state_out))
      else $error("transmit state moved without a write");
   ts_merge_a: assert property (w4 |=> ((transmit_state_out ^
      $past(transmit_state_out)) & (transmit_state_out ^
      $past(mgmt_req_in.data))) == 8'h00) else $error("bad merge");
   irq_quiet_a: assert property (!mgmt_req_in.wr && !ev |=>
      $stable(irq_n_out)) else $error("interrupt moved without cause");
   cmp_quiet_a: assert property (mgmt_req_in.wr && !ev && !bad &&
      mgmt_req_in.addr inside {[5'h1A:5'h1D]} |=> $stable(irq_n_out))
      else $error("compare write moved interrupt");
   ts_read_a: assert property (mgmt_req_in.rd && mgmt_req_in.addr ==
      ADDR_TRANSMIT_STATE |=> mgmt_bus_data_out == $past(transmit_state_out))
      else $error("transmit state read wrong");
   cover property (mgmt_req_in.wr && ro);
   cover property ($fell(irq_n_out));
   cover property (w4);
endmodule : phy_interrupt_condition_logic_assertions
bind phy_interrupt_condition_logic phy_interrupt_condition_logic_assertions
   #(.ODD_PARITY(ODD_PARITY)) u_assert (.clk_sys_in(clk_sys_in),
   .srst_in(srst_in), .mgmt_req_in(mgmt_req_in),
   .mgmt_bus_parity_en_pin_in(mgmt_bus_parity_en_pin_in),
   .request_parity_err_in(request_parity_err_in),
   .upper_condition_set_in(upper_condition_set_in),
   .receive_a_set_in(receive_a_set_in), .receive_b_set_in(receive_b_set_in),
   .mgmt_bus_data_out(mgmt_bus_data_out),
   .transmit_state_out(transmit_state_out), .irq_n_out(irq_n_out));

// >>> tb/test_phy_interrupt_condition_logic.sv
// self-checking bench of the interrupt condition logic
`timescale 1ns/1ns
module test_phy_interrupt_condition_logic;
   import phy_int_pkg::*;
   localparam logic [4:0] cnd = ADDR_INTERRUPT_CONDITION;
   localparam logic [4:0] cmp = ADDR_INTERRUPT_COMPARE;
   localparam logic [4:0] msk = ADDR_INTERRUPT_MASK;
   logic clk_sys_in = 1'b0;
   logic srst_in = 1'b1;
   logic pen = 1'b0;
   logic rperr = 1'b0;
   logic [3:0] up = 4'h0;
   logic [7:0] rxa = 8'h00;
   logic [7:0] rxb = 8'h00;
   logic [7:0] rdata, ts, q;
   logic irq_n;
   mgmt_req_t req;
   int errors = 0;
   int checks = 0;
   logic [4:0] ro [10] = '{5'h07, 5'h08, 5'h10, 5'h13, 5'h14, 5'h16,
      5'h18, 5'h19, 5'h1E, 5'h1F};
   phy_interrupt_condition_logic u_dut (.clk_sys_in(clk_sys_in),
      .srst_in(srst_in), .mgmt_req_in(req),
      .mgmt_bus_parity_en_pin_in(pen), .request_parity_err_in(rperr),
      .upper_condition_set_in(up), .receive_a_set_in(rxa),
      .receive_b_set_in(rxb), .mgmt_bus_data_out(rdata),
      .transmit_state_out(ts), .irq_n_out(irq_n));
   mgmt_host_model u_host (.clk_in(clk_sys_in), .rdata_in(rdata),
      .req_out(req));
   initial begin
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   task automatic chk(input string w, input logic [7:0] s, e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", w, e, s);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      u_host.access(1'b1, a, d, 1'b0, q);
   endtask : wr
   task automatic rc(input string w, input logic [4:0] a,
      input logic [7:0] e);
      u_host.access(1'b0, a, 8'h00, 1'b0, q);
      chk(w, q, e);
   endtask : rc
   task automatic irq(input logic e);
      chk("irq", {7'h00, irq_n}, {7'h00, e});
   endtask : irq
   task automatic clr(input logic [4:0] c, a, input logic [7:0] seen);
      u_host.cond_write(c, a, seen, 8'h00);
   endtask : clr
   task automatic pulse(input logic [20:0] v);
      @(posedge clk_sys_in);
      {up, rxa, rxb, rperr} <= v;
      @(posedge clk_sys_in);
      {up, rxa, rxb, rperr} <= '0;
   endtask : pulse
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   // the sequence needs about 200 cycles; allow fifty times that
   initial begin
      #400000;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (12) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      rc("cond reset", cnd, RST_INTERRUPT_CONDITION);
      rc("mask reset", msk, RST_INTERRUPT_MASK);
      rc("ts reset", ADDR_TRANSMIT_STATE, RST_TRANSMIT_STATE);
      irq(1'b1);
      $display("test reset done");
      wr(msk, 8'h04);
      foreach (ro[i]) begin
         wr(ro[i], 8'hFF);
         rc("ro read", ro[i], READ_ZERO);
         rc("reject", cnd, 8'h04);
         irq(1'b0);
         clr(cmp, cnd, 8'h04);
         irq(1'b1);
      end
      chk("ts kept", ts, RST_TRANSMIT_STATE);
      $display("test reject done");
      wr(msk, 8'h02);
      u_host.access(1'b1, cmp, 8'h02, 1'b1, q);
      rc("parity off", cnd, 8'h00);
      @(posedge clk_sys_in) pen <= 1'b1;
      u_host.access(1'b1, cmp, 8'h02, 1'b1, q);
      rc("parity on", cnd, 8'h02);
      irq(1'b0);
      clr(cmp, cnd, 8'h02);
      $display("test parity done");
      pulse(21'h000001);
      rc("dpe off", cnd, 8'h00);
      u_host.cond_write(ADDR_TRANSMIT_STATE_COMPARE, ADDR_TRANSMIT_STATE,
         RST_TRANSMIT_STATE, 8'hE2);
      chk("ts write", ts, 8'hE2);
      pulse(21'h000001);
      rc("dpe on", cnd, 8'h01);
      clr(cmp, cnd, 8'h00);
      rc("inhibit", cnd, 8'h09);
      repeat (20) @(posedge clk_sys_in);
      rc("inhibit held", cnd, 8'h09);
      clr(cmp, cnd, 8'h09);
      rc("inhibit clear", cnd, 8'h00);
      $display("test inhibit done");
      pulse({4'hF, 8'h81, 8'h18, 1'b0});
      wr(msk, 8'hF0);
      rc("upper", cnd, 8'hF0);
      irq(1'b0);
      clr(ADDR_RECEIVE_COMPARE_A, ADDR_RECEIVE_CONDITION_A, 8'h00);
      rc("rx a kept", ADDR_RECEIVE_CONDITION_A, 8'h81);
      clr(ADDR_RECEIVE_COMPARE_B, ADDR_RECEIVE_CONDITION_B, 8'h18);
      rc("rx b clear", ADDR_RECEIVE_CONDITION_B, 8'h00);
      rc("rx a flag", cnd, 8'hF8);
      clr(cmp, cnd, 8'hF8);
      irq(1'b1);
      $display("test receive done");
      wrap_up();
   end
endmodule : test_phy_interrupt_condition_logic
